/* hw/dch_pkg.sv */
// shared constants and types for the memory card host controller
package dch_pkg;
    localparam int unsigned CLK_NS        = 10;
    // strobe timing, least times rounded up to whole cycles
    localparam int unsigned T_RP_NS       = 60;
    localparam int unsigned T_RCD_NS      = 15;
    localparam int unsigned T_RAS_NS      = 80;
    localparam int unsigned T_CAC_NS      = 30;
    localparam int unsigned T_CP_NS       = 10;
    localparam int unsigned T_CSR_NS      = 20;
    localparam int unsigned SYNC_CYC      = 2;
    localparam int unsigned WAIT_W        = 4;
    localparam logic [WAIT_W-1:0] RP_CYC  = WAIT_W'((T_RP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [WAIT_W-1:0] RCD_CYC = WAIT_W'((T_RCD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [WAIT_W-1:0] RAS_CYC = WAIT_W'((T_RAS_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [WAIT_W-1:0] CAS_CYC = WAIT_W'((T_CAC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
    localparam logic [WAIT_W-1:0] CP_CYC  = WAIT_W'((T_CP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [WAIT_W-1:0] CSR_CYC = WAIT_W'((T_CSR_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [WAIT_W-1:0] WAIT_ONE = 4'h1;
    // refresh obligation: every row once per window, longest time rounded down
    localparam int unsigned ROW_COUNT     = 512;
    localparam int unsigned REF_WINDOW_NS = 64_000_000;
    localparam int unsigned REF_INT_NS    = REF_WINDOW_NS / ROW_COUNT;
    localparam int unsigned REF_INT_CYC   = REF_INT_NS / CLK_NS;
    localparam int unsigned POWERUP_NS    = 100_000;
    localparam int unsigned POWERUP_CYC   = (POWERUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned TMR_W         = 24;
    localparam int unsigned PEND_W        = 4;
    localparam logic [PEND_W-1:0] WAKE_REFRESHES = 4'h8;
    localparam logic [PEND_W-1:0] PEND_MAX       = 4'hf;
    localparam logic [PEND_W-1:0] PEND_ONE       = 4'h1;
    // pin widths and field layout
    localparam int unsigned ADDR_W   = 9;
    localparam int unsigned DATA_W   = 36;
    localparam int unsigned HALF_W   = 18;
    localparam int unsigned STROBES  = 4;
    localparam int unsigned IDENT_W  = 8;
    localparam int unsigned BANK_W   = 2;
    localparam int unsigned REQ_A_W  = BANK_W + 2 * ADDR_W;
    localparam int unsigned COL_LSB  = 0;
    localparam int unsigned ROW_LSB  = ADDR_W;
    localparam int unsigned BANK_LSB = 2 * ADDR_W;
    localparam logic [STROBES-1:0] STROBE_NONE = 4'h0;
    localparam logic [STROBES-1:0] STROBE_ALL  = 4'hf;

    typedef enum logic [7:0] {
        ST_IDLE    = 8'h01,
        ST_ROWSET  = 8'h02,
        ST_RASWAIT = 8'h04,
        ST_COLSET  = 8'h08,
        ST_CASLO   = 8'h10,
        ST_CASHI   = 8'h20,
        ST_PRECH   = 8'h40,
        ST_CBR     = 8'h80
    } dch_state_e;
endpackage : dch_pkg

/* hw/dch_refresh_if.sv */
// refresh scheduling handshake between controller and its interval timer
`timescale 1ns/1ps
`default_nettype none
interface dch_refresh_if;
    logic wakeDone;
    logic refreshDue;
    logic refreshTaken;
    modport timer (output wakeDone, output refreshDue, input refreshTaken);
    modport ctrl  (input wakeDone, input refreshDue, output refreshTaken);
endinterface : dch_refresh_if
`default_nettype wire

/* hw/dch_refresh_timer.sv */
// power-up pause, wake-up refresh burst and periodic refresh debt counter
`timescale 1ns/1ps
`default_nettype none
module dch_refresh_timer #(
    parameter int unsigned PWRUP_CYC  = dch_pkg::POWERUP_CYC,
    parameter int unsigned REFINT_CYC = dch_pkg::REF_INT_CYC
) (
    input  wire logic     clk_sys,
    input  wire logic     arst_n,
    input  wire logic     ce,
    dch_refresh_if.timer  rif
);
    logic [dch_pkg::TMR_W-1:0]  cntQ;
    logic [dch_pkg::PEND_W-1:0] pendQ;
    logic [dch_pkg::PEND_W-1:0] pendD;
    logic                       armedQ;
    logic                       wakeQ;

    wire logic [dch_pkg::TMR_W-1:0] limit = armedQ ? dch_pkg::TMR_W'(REFINT_CYC - 1)
                                                   : dch_pkg::TMR_W'(PWRUP_CYC - 1);
    wire logic tick    = (cntQ == limit);
    wire logic overdue = tick && armedQ && (pendQ == dch_pkg::PEND_MAX);

    // a tick in the same cycle as a taken refresh leaves the debt unchanged
    always_comb begin
        pendD = pendQ;
        if (tick && !armedQ) begin
            pendD = dch_pkg::WAKE_REFRESHES; // RULE_16
        end else if (tick && !rif.refreshTaken) begin
            pendD = (pendQ == dch_pkg::PEND_MAX) ? pendQ : pendQ + dch_pkg::PEND_ONE; // RULE_03
        end else if (!tick && rif.refreshTaken && pendQ != '0) begin
            pendD = pendQ - dch_pkg::PEND_ONE;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cntQ   <= '0;
            pendQ  <= '0;
            armedQ <= 1'b0;
            wakeQ  <= 1'b0;
        end else if (ce) begin
            cntQ   <= tick ? '0 : cntQ + dch_pkg::TMR_W'(1);
            pendQ  <= pendD;
            armedQ <= armedQ | tick;
            // debt saturated means the window was missed: wake up again
            if (overdue) begin
                wakeQ <= 1'b0; // RULE_16
            end else if (armedQ && pendQ == '0) begin
                wakeQ <= 1'b1;
            end
        end
    end

    assign rif.wakeDone   = wakeQ;
    assign rif.refreshDue = armedQ && (pendQ != '0);

    debt_grows_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_03
        ce && tick && armedQ && !rif.refreshTaken && pendQ < dch_pkg::PEND_MAX |=> pendQ == $past(pendQ) + 1'b1)
        else $error("refresh debt did not grow on interval tick");
    wake_burst_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_16
        ce && tick && !armedQ |=> pendQ == dch_pkg::WAKE_REFRESHES && !wakeQ)
        else $error("wake-up burst not scheduled after power-up pause");
endmodule : dch_refresh_timer
`default_nettype wire

/* hw/dch_card_host.sv */
// host controller driving the buffered memory card through its strobe pins
// Contract
// [RULE_01] wide mode: row strobes 0,1 gate low half, 2,3 high half
// [RULE_02] narrow mode: host ties data halves and column strobes 0-2, 1-3
// [RULE_03] all 512 rows refreshed within every 64 ms window
// [RULE_04] card refreshes the addressed row on every row strobe cycle
// [RULE_05] retention refresh preferred: column-first cycles spread over the interval
// [RULE_06] otherwise column-first refresh preferred over other refresh modes
// [RULE_07] row half latched by row strobe fall, column half by column fall
// [RULE_08] write-enable high means read, low means write
// [RULE_09] card captures write data on the column strobe fall
// [RULE_10] write-enable falls before column strobe falls
// [RULE_11] data pins shared, direction follows write-enable
// [RULE_12] page access starts with row latch then column latch
// [RULE_13] column strobe may pulse repeatedly inside one open row
// [RULE_14] raising strobes ends page and cycle, precharge while row strobe high
// [RULE_15] column-first cycle uses the card's internal row counter
// [RULE_16] 100 us pause then eight refreshes, repeated when window missed; on a miss code drops wakeDone until the debt drains, no new pause
// [RULE_17] column strobe low at row fall keeps old output
// [RULE_18] hidden refresh may follow read or write
// [RULE_19] column-first refresh: column before row, write-enable high, data released
// [RULE_20] data released with strobes high or during refresh
// [RULE_21] card identity lines read as static levels
`timescale 1ns/1ps
`default_nettype none
module dch_card_host #(
    parameter int unsigned PWRUP_CYC  = dch_pkg::POWERUP_CYC,
    parameter int unsigned REFINT_CYC = dch_pkg::REF_INT_CYC
) (
    input  wire logic                          clk_sys,
    input  wire logic                          arst_n,
    input  wire logic                          ce,
    input  wire logic                          cfgNarrow,
    input  wire logic                          reqValid,
    output logic                               reqReady,
    input  wire logic                          reqWrite,
    input  wire logic [dch_pkg::REQ_A_W-1:0]   reqAddr,
    input  wire logic [dch_pkg::DATA_W-1:0]    reqData,
    input  wire logic [dch_pkg::STROBES-1:0]   reqByteEn,
    output logic                               rspValid,
    output logic [dch_pkg::DATA_W-1:0]         rspData,
    output logic                               ready,
    output logic [dch_pkg::IDENT_W-1:0]        cardIdent,
    output logic [dch_pkg::STROBES-1:0]        rowStrobeN,
    output logic [dch_pkg::STROBES-1:0]        columnByteStrobeN,
    output logic                               weN,
    output logic [dch_pkg::ADDR_W-1:0]         muxAddrLines,
    output logic [dch_pkg::DATA_W-1:0]         sharedDataLinesOut,
    output logic [dch_pkg::DATA_W-1:0]         sharedDataLinesOe,
    input  wire logic [dch_pkg::DATA_W-1:0]    sharedDataLinesIn,
    input  wire logic [dch_pkg::IDENT_W-1:0]   cardIdentLinesIn
);

    dch_refresh_if rif ();

    dch_refresh_timer #(
        .PWRUP_CYC  (PWRUP_CYC),
        .REFINT_CYC (REFINT_CYC)
    ) uTimer (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .ce      (ce),
        .rif     (rif)
    );

    dch_pkg::dch_state_e                stateQ;
    dch_pkg::dch_state_e                stateD;
    logic [dch_pkg::WAIT_W-1:0]         waitQ;
    logic [dch_pkg::WAIT_W-1:0]         rasAgeQ;
    logic                               cbrRasQ;
    logic                               writeQ;
    logic [dch_pkg::BANK_W-1:0]         bankQ;
    logic [dch_pkg::ADDR_W-1:0]         rowQ;
    logic [dch_pkg::ADDR_W-1:0]         colQ;
    logic [dch_pkg::DATA_W-1:0]         dataQ;
    logic [dch_pkg::STROBES-1:0]        beQ;
    logic [dch_pkg::DATA_W-1:0]         dinSync1Q;
    logic [dch_pkg::DATA_W-1:0]         dinSync2Q;
    logic [dch_pkg::IDENT_W-1:0]        idSync1Q;
    logic [dch_pkg::IDENT_W-1:0]        idSync2Q;
    logic [dch_pkg::STROBES-1:0]        rasMaskD;
    logic [dch_pkg::STROBES-1:0]        casMaskD;
    logic [dch_pkg::STROBES-1:0]        rasNQ;
    logic [dch_pkg::STROBES-1:0]        casNQ;
    logic                               weNQ;
    logic [dch_pkg::ADDR_W-1:0]         addrD;
    logic [dch_pkg::ADDR_W-1:0]         addrQ;
    logic                               oeD;
    logic                               oeQ;
    logic [dch_pkg::DATA_W-1:0]         doutQ;
    logic                               rspValidQ;
    logic [dch_pkg::DATA_W-1:0]         rspDataQ;

    // wide mode pairs strobes 0+2 and 1+3 into one bank; narrow mode one strobe per bank
    function automatic logic [dch_pkg::STROBES-1:0] rowSelect(input logic [dch_pkg::BANK_W-1:0] bank,
                                                             input logic narrow);
        logic [dch_pkg::STROBES-1:0] sel;
        sel = dch_pkg::STROBE_NONE;
        if (narrow) begin
            sel[bank] = 1'b1; // RULE_02
        end else begin
            sel[bank[0]]     = 1'b1; // RULE_01
            sel[bank[0] + 2] = 1'b1; // RULE_01
        end
        return sel;
    endfunction : rowSelect

    // reads open every lane; writes follow byte enables, duplicated when narrow
    function automatic logic [dch_pkg::STROBES-1:0] colSelect(input logic [dch_pkg::STROBES-1:0] be,
                                                             input logic wr, input logic narrow);
        logic [dch_pkg::STROBES-1:0] sel;
        sel = wr ? be : dch_pkg::STROBE_ALL;
        if (narrow) begin
            sel = {sel[1:0], sel[1:0]}; // RULE_02
        end
        return sel;
    endfunction : colSelect

    function automatic logic [dch_pkg::WAIT_W-1:0] waitLoad(input dch_pkg::dch_state_e st, input logic ras);
        case (st)
            dch_pkg::ST_RASWAIT: return dch_pkg::RCD_CYC - dch_pkg::WAIT_ONE;
            dch_pkg::ST_CASLO:   return dch_pkg::CAS_CYC - dch_pkg::WAIT_ONE;
            dch_pkg::ST_CASHI:   return dch_pkg::CP_CYC - dch_pkg::WAIT_ONE;
            dch_pkg::ST_PRECH:   return dch_pkg::RP_CYC - dch_pkg::WAIT_ONE;
            dch_pkg::ST_CBR:     return ras ? dch_pkg::RAS_CYC - dch_pkg::WAIT_ONE
                                            : dch_pkg::CSR_CYC - dch_pkg::WAIT_ONE;
            default:             return '0;
        endcase
    endfunction : waitLoad

    wire logic [dch_pkg::ADDR_W-1:0] reqRow  = reqAddr[dch_pkg::ROW_LSB +: dch_pkg::ADDR_W];
    wire logic [dch_pkg::ADDR_W-1:0] reqCol  = reqAddr[dch_pkg::COL_LSB +: dch_pkg::ADDR_W];
    wire logic [dch_pkg::BANK_W-1:0] reqBank = reqAddr[dch_pkg::BANK_LSB +: dch_pkg::BANK_W];
    wire logic waitDone = (waitQ == '0);
    wire logic rasMet   = (rasAgeQ >= dch_pkg::RAS_CYC);
    wire logic pageHit  = (reqBank == bankQ) && (reqRow == rowQ);
    wire logic canStart = rif.wakeDone && !rif.refreshDue;
    wire logic idleTake = (stateQ == dch_pkg::ST_IDLE) && canStart;
    // page kept open only for hits and only while no refresh is owed
    wire logic pageTake = (stateQ == dch_pkg::ST_CASHI) && waitDone && pageHit && !rif.refreshDue; // RULE_13 RULE_18
    wire logic accept   = reqValid && reqReady;
    wire logic curWrite = accept ? reqWrite : writeQ;
    wire logic [dch_pkg::ADDR_W-1:0] curCol  = accept ? reqCol : colQ;
    wire logic [dch_pkg::DATA_W-1:0] curData = accept ? reqData : dataQ;
    wire logic [dch_pkg::DATA_W-1:0] wideData = cfgNarrow ? {curData[dch_pkg::HALF_W-1:0],
                                                             curData[dch_pkg::HALF_W-1:0]} : curData; // RULE_02
    wire logic inAccess = (stateD == dch_pkg::ST_RASWAIT) || (stateD == dch_pkg::ST_COLSET)
                       || (stateD == dch_pkg::ST_CASLO) || (stateD == dch_pkg::ST_CASHI);
    wire logic cbrRasD  = (stateD == dch_pkg::ST_CBR) && (cbrRasQ || (stateQ == dch_pkg::ST_CBR && waitDone));

    assign reqReady = ce && (idleTake || pageTake);
    assign rif.refreshTaken = ce && cbrRasD && !cbrRasQ;

    always_comb begin
        stateD = stateQ;
        case (stateQ)
            dch_pkg::ST_IDLE: begin
                if (rif.refreshDue) begin
                    stateD = dch_pkg::ST_CBR; // RULE_05 RULE_06
                end else if (accept) begin
                    stateD = dch_pkg::ST_ROWSET;
                end
            end
            dch_pkg::ST_ROWSET:  stateD = dch_pkg::ST_RASWAIT; // RULE_12
            dch_pkg::ST_RASWAIT: stateD = waitDone ? dch_pkg::ST_COLSET : stateQ;
            dch_pkg::ST_COLSET:  stateD = dch_pkg::ST_CASLO;
            dch_pkg::ST_CASLO:   stateD = waitDone ? dch_pkg::ST_CASHI : stateQ;
            dch_pkg::ST_CASHI: begin
                if (accept) begin
                    stateD = dch_pkg::ST_COLSET; // RULE_13
                end else if (waitDone && rasMet) begin
                    stateD = dch_pkg::ST_PRECH; // RULE_14
                end
            end
            dch_pkg::ST_PRECH:   stateD = waitDone ? dch_pkg::ST_IDLE : stateQ;
            dch_pkg::ST_CBR:     stateD = (waitDone && cbrRasQ) ? dch_pkg::ST_PRECH : stateQ;
            default:             stateD = dch_pkg::ST_IDLE;
        endcase
    end

    // pin values follow the next state so the pins line up with stateQ
    always_comb begin
        rasMaskD = dch_pkg::STROBE_NONE;
        casMaskD = dch_pkg::STROBE_NONE;
        addrD    = '0; // RULE_15
        oeD      = 1'b0; // RULE_20
        if (inAccess) begin
            rasMaskD = rowSelect(bankQ, cfgNarrow); // RULE_07
        end
        if (stateD == dch_pkg::ST_CBR) begin
            casMaskD = dch_pkg::STROBE_ALL; // RULE_19
            rasMaskD = cbrRasD ? dch_pkg::STROBE_ALL : dch_pkg::STROBE_NONE; // RULE_19
        end
        if (stateD == dch_pkg::ST_CASLO) begin
            casMaskD = colSelect(beQ, writeQ, cfgNarrow); // RULE_07
        end
        if (stateD == dch_pkg::ST_ROWSET || stateD == dch_pkg::ST_RASWAIT) begin
            addrD = (stateD == dch_pkg::ST_ROWSET && accept) ? reqRow : rowQ;
        end else if (stateD == dch_pkg::ST_COLSET || stateD == dch_pkg::ST_CASLO || stateD == dch_pkg::ST_CASHI) begin
            addrD = curCol;
        end
        if (stateD == dch_pkg::ST_COLSET || stateD == dch_pkg::ST_CASLO) begin
            oeD = curWrite; // RULE_11
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stateQ  <= dch_pkg::ST_IDLE;
            waitQ   <= '0;
            rasAgeQ <= '0;
            cbrRasQ <= 1'b0;
        end else if (ce) begin
            stateQ  <= stateD;
            cbrRasQ <= cbrRasD;
            waitQ   <= (stateD != stateQ || cbrRasD != cbrRasQ) ? waitLoad(stateD, cbrRasD)
                     : (waitDone ? waitQ : waitQ - dch_pkg::WAIT_ONE);
            rasAgeQ <= (stateD == dch_pkg::ST_ROWSET) ? '0
                     : (rasMet ? rasAgeQ : rasAgeQ + dch_pkg::WAIT_ONE);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            writeQ <= 1'b0;
            bankQ  <= '0;
            rowQ   <= '0;
            colQ   <= '0;
            dataQ  <= '0;
            beQ    <= '0;
        end else if (ce && accept) begin
            writeQ <= reqWrite;
            bankQ  <= reqBank;
            rowQ   <= reqRow;
            colQ   <= reqCol;
            dataQ  <= reqData;
            beQ    <= reqByteEn;
        end
    end

    // pins registered; write-enable set from row setup on so it leads the column fall
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rasNQ <= dch_pkg::STROBE_ALL;
            casNQ <= dch_pkg::STROBE_ALL;
            weNQ  <= 1'b1;
            addrQ <= '0;
            oeQ   <= 1'b0;
            doutQ <= '0;
        end else if (ce) begin
            rasNQ <= ~rasMaskD;
            casNQ <= ~casMaskD;
            weNQ  <= !((inAccess || stateD == dch_pkg::ST_ROWSET) && curWrite); // RULE_08 RULE_10
            addrQ <= addrD;
            oeQ   <= oeD;
            doutQ <= wideData; // RULE_09
        end
    end

    // data and identity pins come from outside the clock domain
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dinSync1Q <= '0;
            dinSync2Q <= '0;
            idSync1Q  <= '0;
            idSync2Q  <= '0;
            cardIdent <= '0;
            rspValidQ <= 1'b0;
            rspDataQ  <= '0;
        end else if (ce) begin
            dinSync1Q <= sharedDataLinesIn;
            dinSync2Q <= dinSync1Q;
            idSync1Q  <= cardIdentLinesIn;
            idSync2Q  <= idSync1Q;
            cardIdent <= idSync2Q; // RULE_21
            rspValidQ <= (stateQ == dch_pkg::ST_CASLO) && waitDone && !writeQ;
            if ((stateQ == dch_pkg::ST_CASLO) && waitDone && !writeQ) begin
                rspDataQ <= cfgNarrow ? {{dch_pkg::HALF_W{1'b0}}, dinSync2Q[dch_pkg::HALF_W-1:0]} : dinSync2Q;
            end
        end
    end

    assign rowStrobeN         = rasNQ;
    assign columnByteStrobeN  = casNQ;
    assign weN                = weNQ;
    assign muxAddrLines       = addrQ;
    assign sharedDataLinesOut = doutQ;
    assign sharedDataLinesOe  = {dch_pkg::DATA_W{oeQ}};
    assign rspValid           = rspValidQ;
    assign rspData            = rspDataQ;
    assign ready              = rif.wakeDone;

    wire logic casAny = (casNQ != dch_pkg::STROBE_ALL);
    wire logic rasAny = (rasNQ != dch_pkg::STROBE_ALL);

    sequence closedRow;
        rasNQ == dch_pkg::STROBE_ALL && casNQ == dch_pkg::STROBE_ALL;
    endsequence

    split_banks_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_01
        !cfgNarrow && rasAny |-> rasNQ[0] == rasNQ[2] && rasNQ[1] == rasNQ[3])
        else $error("wide mode row strobes not paired across halves");
    narrow_tie_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_02
        cfgNarrow |-> casNQ[1:0] == casNQ[3:2]
                      && doutQ[dch_pkg::HALF_W-1:0] == doutQ[dch_pkg::DATA_W-1:dch_pkg::HALF_W])
        else $error("narrow mode lanes not duplicated");
    col_after_row_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_07
        $rose(casAny) && stateQ == dch_pkg::ST_CASLO |-> rasAny && addrQ == colQ && $past(rasAny, 2))
        else $error("column strobe fell without an open row");
    early_write_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_10
        $rose(casAny) && stateQ == dch_pkg::ST_CASLO && writeQ |-> $past(weNQ) == 1'b0 && oeQ)
        else $error("write enable not low before column strobe");
    dir_by_we_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_11
        oeQ |-> !weNQ)
        else $error("data driven while write enable high");
    precharge_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_14
        ce && $rose(rasNQ == dch_pkg::STROBE_ALL) |-> closedRow [*6])
        else $error("precharge shorter than required");
    cbr_order_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_19
        $fell(rasNQ == dch_pkg::STROBE_ALL) && stateQ == dch_pkg::ST_CBR
        |-> $past(casNQ, 2) == dch_pkg::STROBE_NONE && weNQ && !oeQ)
        else $error("column-first refresh order broken");
    hiz_idle_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_20
        (rasNQ == dch_pkg::STROBE_ALL && casNQ == dch_pkg::STROBE_ALL) || stateQ == dch_pkg::ST_CBR |-> !oeQ)
        else $error("data driven outside an access");
    fresh_cycle_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_17
        $fell(rasNQ == dch_pkg::STROBE_ALL) && stateQ != dch_pkg::ST_CBR |-> !casAny)
        else $error("column strobe low at row strobe fall");
    wake_first_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_16
        stateQ == dch_pkg::ST_ROWSET |-> rif.wakeDone)
        else $error("access before wake-up refreshes");
endmodule : dch_card_host
`default_nettype wire

/* sim/dch_card_model.sv */
// behavioural memory card answering the host strobes
`timescale 1ns/1ps
`default_nettype none
module dch_card_model #(
    parameter logic [7:0] IDENT = 8'h5a // arbitrary identity pattern
) (
    input  wire logic [3:0]  rowStrobeN,
    input  wire logic [3:0]  columnByteStrobeN,
    input  wire logic        weN,
    input  wire logic [8:0]  muxAddrLines,
    input  wire logic [35:0] hostData,
    output var logic [35:0]  cardData,
    output var logic [7:0]   cardIdentLines,
    output var int           refreshCount
);
    logic [35:0]       mem [logic [21:0]];
    logic [35:0]       outQ = 36'h0;
    logic [8:0]        rowQ = 9'h0;
    logic              cbrQ = 1'b0;
    wire  logic [21:0] key = {rowStrobeN, rowQ, muxAddrLines};
    initial refreshCount = 0;
    assign cardIdentLines = IDENT;
    // released lines show the inverse, so stale data never passes
    assign cardData = (!(&rowStrobeN) && !(&columnByteStrobeN) && weN && !cbrQ) ? outQ : ~outQ;
    always @(negedge (&rowStrobeN)) begin
        cbrQ = !(&columnByteStrobeN);
        refreshCount += cbrQ;
        if (!cbrQ) rowQ = muxAddrLines;
    end
    always @(negedge (&columnByteStrobeN)) begin
        for (int i = 0; i < 4; i++)
            if (!(&rowStrobeN) && !weN && !columnByteStrobeN[i]) mem[key][9*i+:9] = hostData[9*i+:9];
        if (!(&rowStrobeN)) outQ = mem[key];
    end
endmodule : dch_card_model
`default_nettype wire

/* sim/tb.sv */
// self-checking bench for the memory card host controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk_sys = 1'b0, arst_n = 1'b0, reqValid = 1'b0, reqWrite = 1'b0, reqReady, rspValid, ready, weN;
    logic        cfgNarrow = 1'b0;
    logic [19:0] reqAddr = 20'h0;
    logic [35:0] reqData = 36'h0, rspData, sharedDataLinesOut, sharedDataLinesOe, cardData;
    logic [7:0]  cardIdent, cardIdentLinesIn;
    logic [3:0]  reqByteEn = 4'h0, rowStrobeN, columnByteStrobeN;
    logic [8:0]  muxAddrLines;
    int          refreshCount, base, err_total = 0, num_checks = 0, cyc = 0;
    wire  logic [35:0] sharedDataLinesIn = sharedDataLinesOe & sharedDataLinesOut | ~sharedDataLinesOe & cardData;
    always #5 clk_sys = ~clk_sys;
    dch_card_host #(.PWRUP_CYC(50), .REFINT_CYC(100)) dut_u (.clk_sys, .arst_n, .ce(1'b1), .cfgNarrow, .reqValid,
        .reqReady, .reqWrite, .reqAddr, .reqData, .reqByteEn, .rspValid, .rspData, .ready, .cardIdent, .rowStrobeN,
        .columnByteStrobeN, .weN, .muxAddrLines, .sharedDataLinesOut, .sharedDataLinesOe, .sharedDataLinesIn,
        .cardIdentLinesIn);
    dch_card_model card_u (.rowStrobeN, .columnByteStrobeN, .weN, .muxAddrLines, .hostData(sharedDataLinesOut),
        .cardData, .cardIdentLines(cardIdentLinesIn), .refreshCount);
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done
    // raised a falling edge after any drop; the 1 ns pause lets the combinational ready settle
    task automatic req(input logic w, input logic [19:0] a, input logic [35:0] d, input logic [3:0] be);
        @(negedge clk_sys);
        {reqValid, reqWrite, reqAddr, reqData, reqByteEn} = {1'b1, w, a, d, be};
        #1;
        while (reqReady !== 1'b1) @(negedge clk_sys);
        @(negedge clk_sys);
        reqValid = 1'b0;
    endtask : req
    task automatic wt_rsp(input logic [35:0] e);
        repeat (40) if (rspValid !== 1'b1) @(negedge clk_sys);
        chk({35'h0, rspValid}, 36'h1);
        chk(rspData, e);
    endtask : wt_rsp
    task automatic rd(input logic [19:0] a, input logic [35:0] e);
        req(1'b0, a, 36'h0, 4'hf);
        wt_rsp(e);
    endtask : rd
    // mode changes only under reset, as the controller expects it stable
    task automatic t_wake(input logic narrow);
        arst_n = 1'b0;
        cfgNarrow = narrow;
        base = refreshCount;
        repeat (20) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (3000) if (ready !== 1'b1) @(negedge clk_sys);
        chk({35'h0, refreshCount - base >= 8}, 36'h1);
        chk({28'h0, cardIdent}, 36'h5a);
        $display("wake done");
    endtask : t_wake
    task automatic t_page;
        req(1'b1, 20'h00a03, 36'h123456789, 4'hf);
        req(1'b1, 20'h00a03, 36'hfedcba987, 4'h1);
        req(1'b1, 20'h40a03, 36'h0aaaa5555, 4'hf);
        req(1'b1, 20'h40a04, 36'h876543210, 4'hf);
        rd(20'h00a03, 36'h123456787);
        req(1'b0, 20'h40a03, 36'h0, 4'hf);
        req(1'b0, 20'h40a04, 36'h0, 4'hf);
        chk(rspData, 36'h0aaaa5555);
        wt_rsp(36'h876543210);
        $display("page done");
    endtask : t_page
    task automatic t_narrow;
        req(1'b1, 20'hc0a05, 36'hfff03abcd, 4'h3);
        rd(20'hc0a05, 36'h00003abcd);
        $display("narrow done");
    endtask : t_narrow
    task automatic t_refresh;
        base = refreshCount;
        repeat (350) @(negedge clk_sys);
        chk({35'h0, refreshCount - base >= 3}, 36'h1);
        rd(20'h00a03, 36'h123456787);
        $display("refresh done");
    endtask : t_refresh
    initial begin
        t_wake(1'b0);
        t_page;
        t_refresh;
        t_wake(1'b1);
        t_narrow;
        test_done;
    end
    always @(negedge clk_sys) begin
        cyc++;
        if (cyc > 20000) begin
            err_total++;
            test_done;
        end
    end
endmodule : tb
`default_nettype wire
